// ---- wam_pkg.sv ----
// constants, register map and defaults for the weld alarm monitor
package wam_pkg;
    // clock and time base
    localparam int CLK_HZ           = 10_000_000;
    localparam int TICK_PERIOD_US   = 1000;
    localparam int MS_TICK_CYCLES   = (TICK_PERIOD_US * (CLK_HZ / 1_000_000));
    localparam int POWERUP_US       = 100;
    localparam int POWERUP_CYCLES   = (POWERUP_US * (CLK_HZ / 1_000_000));

    // register byte offsets
    localparam logic [7:0] OFS_OVL_ALARM  = 8'h00;
    localparam logic [7:0] OFS_CUT_ALARM  = 8'h04;
    localparam logic [7:0] OFS_SET_ALARM  = 8'h08;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h10;
    localparam logic [7:0] OFS_STATUS     = 8'h14;
    localparam logic [7:0] OFS_VERSION    = 8'h18;
    localparam logic [7:0] OFS_PRESET     = 8'h1c;
    localparam logic [7:0] OFS_CFG_BASE   = 8'h20;

    // settings block, one word each from OFS_CFG_BASE
    localparam int CFG_PHASE_LIM  = 0;
    localparam int CFG_PHASE_TIME = 1;
    localparam int CFG_CUR_LIM    = 2;
    localparam int CFG_FREQ_LO    = 3;
    localparam int CFG_FREQ_HI    = 4;
    localparam int CFG_PWR_LIM    = 5;
    localparam int CFG_VOLT_LIM   = 6;
    localparam int CFG_TEMP_THR   = 7;
    localparam int CFG_ENERGY_CUT = 8;
    localparam int CFG_PWR_CUT    = 9;
    localparam int CFG_CUST1_CUT  = 10;
    localparam int CFG_CUST2_CUT  = 11;
    localparam int CFG_TIME_CUT   = 12;
    localparam int CFG_FLO_OFS    = 13;
    localparam int CFG_FHI_OFS    = 14;
    localparam int CFG_ANA_CFG    = 15;
    localparam int CFG_AMPLITUDE  = 16;
    localparam int CFG_NET_ADDR   = 17;
    localparam int CFG_USER_REG   = 18;
    localparam int CFG_COUNT      = 19;

    // factory defaults
    localparam logic [31:0] DEF_PHASE_LIM  = 32'h0000_0200;
    localparam logic [31:0] DEF_PHASE_TIME = 32'h0000_0005;
    localparam logic [31:0] DEF_CUR_LIM    = 32'h0000_f000;
    localparam logic [31:0] DEF_FREQ_LO    = 32'h0000_4e20;
    localparam logic [31:0] DEF_FREQ_HI    = 32'h0000_5208;
    localparam logic [31:0] DEF_PWR_LIM    = 32'h0000_f000;
    localparam logic [31:0] DEF_VOLT_LIM   = 32'h0000_f000;
    localparam logic [31:0] DEF_TEMP_THR   = 32'h0000_0055;
    localparam logic [31:0] DEF_AMPLITUDE  = 32'h0000_0064;
    localparam logic [31:0] DEF_NET_ADDR   = 32'hc0a8_0001;
    localparam logic [31:0] DEF_ZERO       = 32'h0000_0000;

    // arbitrary neutral value for the protected version record
    localparam logic [31:0] VERSION_WORD   = 32'h0001_0000;

    // alarm bit positions
    localparam int OVL_PHASE   = 1;
    localparam int OVL_CURRENT = 2;
    localparam int OVL_FREQ    = 3;
    localparam int OVL_POWER   = 4;
    localparam int OVL_VOLTAGE = 5;
    localparam int OVL_TEMP    = 6;
    localparam int OVL_BRAKE0  = 17;
    localparam int CUT_ENERGY  = 2;
    localparam int CUT_POWER   = 3;
    localparam int CUT_CUST1   = 4;
    localparam int CUT_TIME    = 5;
    localparam int CUT_FREQ_LO = 6;
    localparam int CUT_FREQ_HI = 7;
    localparam int CUT_CUST2   = 8;
    localparam int SET_PRESET  = 2;
    localparam logic [31:0] MAX_PRESET = 32'h0000_0020;

    // interrupt status bits
    localparam int IRQ_OVL  = 0;
    localparam int IRQ_CUT  = 1;
    localparam int IRQ_SET  = 2;
    localparam int IRQ_COLD = 3;

    // power-up sequencing
    typedef enum logic [1:0] {
        PU_WAIT = 2'b01,
        PU_DONE = 2'b10
    } wam_pu_t;

    function automatic logic [31:0] cfg_default(input int idx);
        case (idx)
            CFG_PHASE_LIM:  cfg_default = DEF_PHASE_LIM;
            CFG_PHASE_TIME: cfg_default = DEF_PHASE_TIME;
            CFG_CUR_LIM:    cfg_default = DEF_CUR_LIM;
            CFG_FREQ_LO:    cfg_default = DEF_FREQ_LO;
            CFG_FREQ_HI:    cfg_default = DEF_FREQ_HI;
            CFG_PWR_LIM:    cfg_default = DEF_PWR_LIM;
            CFG_VOLT_LIM:   cfg_default = DEF_VOLT_LIM;
            CFG_TEMP_THR:   cfg_default = DEF_TEMP_THR;
            CFG_AMPLITUDE:  cfg_default = DEF_AMPLITUDE;
            CFG_NET_ADDR:   cfg_default = DEF_NET_ADDR;
            default:        cfg_default = DEF_ZERO;
        endcase
    endfunction : cfg_default
endpackage : wam_pkg

// ---- wam_tick_div.sv ----
// divider that turns the system clock into a one-cycle enable
module wam_tick_div #(
    parameter int DIV = 10
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic rst_i,
    // enable
    output logic      tick_o
);
    logic [15:0] cnt_r;
    wire         wrap = (cnt_r == 16'(DIV - 1));

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_r  <= 16'h0000;
            tick_o <= 1'b0;
        end else begin
            cnt_r  <= wrap ? 16'h0000 : cnt_r + 16'h0001;
            tick_o <= wrap;
        end
    end
endmodule : wam_tick_div

// ---- wam_monitor.sv ----
// alarm supervision, cold-start restore and register port of the weld monitor
// What this block does
// - cold start reloads every setting from defaults
// - cold start keeps version record, reloads settings to defaults
// - overload stops sonics, then aborts cycle
// - phase out of limit for period: bit1
// - current, frequency, power, voltage overload bits 2-5
// - temperature bit6, no clear while hot
// - cutoff stops sonics only, cycle continues
// - sonic energy above cutoff sets bit2
// - sonic peak power above cutoff sets bit3
// - custom analog inputs above cutoff: bits 4, 8
// - sonic-on time above maximum sets bit5
// - frequency below start minus offset: bit6
// - frequency above start plus offset: bit7
// - preset recall above highest preset: bit2
module wam_monitor
    import wam_pkg::*;
#(
    parameter int MS_CYCLES = MS_TICK_CYCLES
) (
    // clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rd_data_o,
    // weld sequencer state
    input  wire logic        weld_active_i,
    input  wire logic        weld_start_i,
    input  wire logic        sonics_on_i,
    input  wire logic        brake_active_i,
    // measurements
    input  wire logic [15:0] phase_i,
    input  wire logic [15:0] current_i,
    input  wire logic [15:0] freq_i,
    input  wire logic [15:0] power_i,
    input  wire logic [15:0] voltage_i,
    input  wire logic [15:0] temp_i,
    input  wire logic [15:0] ana1_i,
    input  wire logic [15:0] ana2_i,
    // connector strap
    input  wire logic        cold_strap_i,
    // outputs
    output logic             sonics_stop_o,
    output logic             cycle_abort_o,
    output logic             irq_o,
    output logic      [15:0] amplitude_o,
    output logic             cold_start_o,
    output logic             ready_o
);
    function automatic logic is_cfg(input logic [7:0] a);
        is_cfg = (a >= OFS_CFG_BASE) && (a < 8'(OFS_CFG_BASE + 4 * CFG_COUNT)) && (a[1:0] == 2'b00);
    endfunction : is_cfg

    function automatic int cfg_idx(input logic [7:0] a);
        cfg_idx = int'((a - OFS_CFG_BASE) >> 2);
    endfunction : cfg_idx

    // time base
    logic tick_ms;
    wam_tick_div #(.DIV(MS_CYCLES)) u_tick (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .tick_o    (tick_ms)
    );

    // power-up and cold start
    logic        strap_s1_r;
    logic        strap_s2_r;
    logic [15:0] pu_cnt_r;
    wam_pu_t     pu_state_r;
    logic        cold_flag_r;

    wire pu_end      = (pu_state_r == PU_WAIT) && (pu_cnt_r == 16'(POWERUP_CYCLES - 1));
    // strap is only looked at in the last power-up cycle
    wire cold_pulse  = pu_end && strap_s2_r;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
        end else begin
            strap_s1_r <= cold_strap_i;
            strap_s2_r <= strap_s1_r;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pu_cnt_r    <= 16'h0000;
            pu_state_r  <= PU_WAIT;
            cold_flag_r <= 1'b0;
        end else begin
            unique case (pu_state_r)
                PU_WAIT: begin
                    pu_cnt_r <= pu_cnt_r + 16'h0001;
                    if (pu_end) begin
                        pu_state_r  <= PU_DONE;
                        cold_flag_r <= strap_s2_r;
                    end
                end
                PU_DONE: begin
                    pu_state_r <= PU_DONE;
                end
                default: begin
                    pu_state_r <= PU_WAIT;
                end
            endcase
        end
    end

    // settings block
    wire        wr_cfg = wr_i && is_cfg(addr_i);
    logic [31:0] cfg_r [CFG_COUNT];

    generate
        for (genvar g = 0; g < CFG_COUNT; g++) begin : g_cfg
            always_ff @(posedge ref_clk_i) begin
                // version word sits outside this array
                if (rst_i || cold_pulse) begin
                    cfg_r[g] <= cfg_default(g);
                end else if (wr_cfg && (cfg_idx(addr_i) == g)) begin
                    cfg_r[g] <= wr_data_i;
                end
            end
        end
    endgenerate

    wire [15:0] phase_lim  = cfg_r[CFG_PHASE_LIM][15:0];
    wire [15:0] phase_time = cfg_r[CFG_PHASE_TIME][15:0];
    wire [15:0] temp_thr   = cfg_r[CFG_TEMP_THR][15:0];
    wire [15:0] flo_ofs    = cfg_r[CFG_FLO_OFS][15:0];
    wire [15:0] fhi_ofs    = cfg_r[CFG_FHI_OFS][15:0];
    wire [31:0] time_cut   = cfg_r[CFG_TIME_CUT];

    // weld measurements
    logic [15:0] phase_cnt_r;
    logic [31:0] energy_r;
    logic [15:0] peak_pwr_r;
    logic [31:0] son_ms_r;
    logic [15:0] start_freq_r;

    wire phase_out = phase_i > phase_lim;
    wire sonic_run = weld_active_i && sonics_on_i;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !phase_out || !weld_active_i) begin
            phase_cnt_r <= 16'h0000;
        end else if (tick_ms && (phase_cnt_r != 16'hffff)) begin
            phase_cnt_r <= phase_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || weld_start_i) begin
            energy_r     <= 32'h0000_0000;
            peak_pwr_r   <= 16'h0000;
            son_ms_r     <= 32'h0000_0000;
            start_freq_r <= rst_i ? 16'h0000 : freq_i;
        end else if (sonic_run) begin
            if (tick_ms) begin
                energy_r <= energy_r + {16'h0000, power_i};
                son_ms_r <= son_ms_r + 32'h0000_0001;
            end
            if (power_i > peak_pwr_r) begin
                peak_pwr_r <= power_i;
            end
        end
    end

    // overload conditions; braking reports in its own bits
    wire phase_trip = phase_out && (phase_cnt_r >= phase_time);
    wire cur_hit    = current_i >= cfg_r[CFG_CUR_LIM][15:0];
    wire freq_out   = (freq_i < cfg_r[CFG_FREQ_LO][15:0]) || (freq_i > cfg_r[CFG_FREQ_HI][15:0]);
    wire pwr_hit    = power_i >= cfg_r[CFG_PWR_LIM][15:0];
    wire volt_hit   = voltage_i >= cfg_r[CFG_VOLT_LIM][15:0];
    wire temp_hot   = temp_i >= temp_thr;
    wire in_weld    = weld_active_i && !brake_active_i;
    wire [4:0] ovl_cond = {volt_hit, pwr_hit, freq_out, cur_hit, phase_trip};

    logic [31:0] ovl_evt;
    always_comb begin
        ovl_evt = 32'h0000_0000;
        ovl_evt[OVL_PHASE +: 5]  = in_weld ? ovl_cond : 5'h00;
        ovl_evt[OVL_BRAKE0 +: 5] = brake_active_i ? ovl_cond : 5'h00;
        ovl_evt[OVL_TEMP]        = temp_hot;
    end

    // cutoff conditions, a zero setting disables its check; custom inputs are enabled by ana_cfg bits instead
    wire [16:0] flo_sum = {1'b0, freq_i} + {1'b0, flo_ofs};
    wire [16:0] fhi_sum = {1'b0, start_freq_r} + {1'b0, fhi_ofs};
    wire [31:0] ana_cfg = cfg_r[CFG_ANA_CFG];

    logic [31:0] cut_evt;
    always_comb begin
        cut_evt = 32'h0000_0000;
        cut_evt[CUT_ENERGY]  = sonic_run && (|cfg_r[CFG_ENERGY_CUT])
            && (energy_r > cfg_r[CFG_ENERGY_CUT]);
        cut_evt[CUT_POWER]   = sonic_run && (|cfg_r[CFG_PWR_CUT])
            && ({16'h0000, peak_pwr_r} > cfg_r[CFG_PWR_CUT]);
        cut_evt[CUT_CUST1]   = weld_active_i && ana_cfg[0]
            && ({16'h0000, ana1_i} > cfg_r[CFG_CUST1_CUT]);
        cut_evt[CUT_CUST2]   = weld_active_i && ana_cfg[1]
            && ({16'h0000, ana2_i} > cfg_r[CFG_CUST2_CUT]);
        cut_evt[CUT_TIME]    = sonic_run && (|time_cut) && (son_ms_r > time_cut);
        cut_evt[CUT_FREQ_LO] = sonic_run && (|flo_ofs)
            && (flo_sum < {1'b0, start_freq_r});
        cut_evt[CUT_FREQ_HI] = sonic_run && (|fhi_ofs)
            && ({1'b0, freq_i} > fhi_sum);
    end

    // setup alarm from preset recall
    logic [31:0] preset_r;
    wire wr_preset  = wr_i && (addr_i == OFS_PRESET);
    wire [31:0] set_evt = {29'h0000_0000, wr_preset && (wr_data_i > MAX_PRESET), 2'b00};

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            preset_r <= 32'h0000_0000;
        end else if (wr_preset) begin
            preset_r <= wr_data_i;
        end
    end

    // sticky alarm groups, write one to clear, a new event wins
    logic [31:0] ovl_r;
    logic [31:0] cut_r;
    logic [31:0] set_r;
    logic [3:0]  irq_stat_r;
    logic [3:0]  irq_mask_r;

    wire [31:0] ovl_clr = (wr_i && addr_i == OFS_OVL_ALARM) ? wr_data_i : 32'h0000_0000;
    wire [31:0] cut_clr = (wr_i && addr_i == OFS_CUT_ALARM) ? wr_data_i : 32'h0000_0000;
    wire [31:0] set_clr = (wr_i && addr_i == OFS_SET_ALARM) ? wr_data_i : 32'h0000_0000;
    // hot heat sink holds its bit against a clear
    wire [31:0] ovl_keep = {25'h000_0000, temp_hot, 6'h00};
    wire [3:0]  irq_clr  = (wr_i && addr_i == OFS_IRQ_STAT) ? wr_data_i[3:0] : 4'h0;
    wire [3:0]  irq_evt  = {cold_pulse, |set_evt, |cut_evt, |ovl_evt};

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ovl_r      <= 32'h0000_0000;
            cut_r      <= 32'h0000_0000;
            set_r      <= 32'h0000_0000;
            irq_stat_r <= 4'h0;
            irq_mask_r <= 4'h0;
        end else begin
            ovl_r      <= (ovl_r & ~(ovl_clr & ~ovl_keep)) | ovl_evt;
            cut_r      <= (cut_r & ~cut_clr) | cut_evt;
            set_r      <= (set_r & ~set_clr) | set_evt;
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_evt;
            if (wr_i && addr_i == OFS_IRQ_MASK) begin
                irq_mask_r <= wr_data_i[3:0];
            end
        end
    end

    // sonics stop and cycle abort
    logic ovl_pend_r;
    wire ovl_now = weld_active_i && (|ovl_evt);
    wire cut_now = weld_active_i && (|cut_evt);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !weld_active_i) begin
            sonics_stop_o <= 1'b0;
            ovl_pend_r    <= 1'b0;
            cycle_abort_o <= 1'b0;
        end else begin
            // cutoff only silences the horn; the cycle runs on
            sonics_stop_o <= sonics_stop_o | ovl_now | cut_now;
            ovl_pend_r    <= ovl_pend_r | ovl_now;
            // abort lags stop by one cycle so sonics are off first
            cycle_abort_o <= cycle_abort_o | ovl_pend_r;
        end
    end

    // status outputs and read port
    wire [31:0] status_w = {29'h0000_0000, weld_active_i, cold_flag_r, pu_state_r == PU_DONE};
    wire [31:0] cfg_rd   = is_cfg(addr_i) ? cfg_r[cfg_idx(addr_i)] : 32'h0000_0000;
    wire [31:0] rd_mux   = (addr_i == OFS_OVL_ALARM) ? ovl_r :
        (addr_i == OFS_CUT_ALARM) ? cut_r :
        (addr_i == OFS_SET_ALARM) ? set_r :
        (addr_i == OFS_IRQ_STAT)  ? {28'h000_0000, irq_stat_r} :
        (addr_i == OFS_IRQ_MASK)  ? {28'h000_0000, irq_mask_r} :
        (addr_i == OFS_STATUS)    ? status_w :
        (addr_i == OFS_VERSION)   ? VERSION_WORD :
        (addr_i == OFS_PRESET)    ? preset_r : cfg_rd;

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rd_data_o    <= 32'h0000_0000;
            irq_o        <= 1'b0;
            amplitude_o  <= 16'h0000;
            cold_start_o <= 1'b0;
            ready_o      <= 1'b0;
        end else begin
            rd_data_o    <= rd_i ? rd_mux : 32'h0000_0000;
            irq_o        <= |(((irq_stat_r & ~irq_clr) | irq_evt) & irq_mask_r);
            amplitude_o  <= cfg_r[CFG_AMPLITUDE][15:0];
            cold_start_o <= cold_flag_r;
            ready_o      <= (pu_state_r == PU_DONE);
        end
    end
endmodule : wam_monitor

// ---- wam_monitor_chk.sv ----
// port-level assertion checker for the weld alarm monitor
module wam_monitor_chk
    import wam_pkg::*;
(
    // clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    // register port
    input wire logic [7:0]  addr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rd_data_o,
    // weld state and measurements
    input wire logic        weld_active_i,
    input wire logic        brake_active_i,
    input wire logic [15:0] current_i,
    input wire logic [15:0] temp_i,
    // outputs
    input wire logic        sonics_stop_o,
    input wire logic        cycle_abort_o,
    input wire logic [15:0] amplitude_o,
    input wire logic        cold_start_o,
    input wire logic        ready_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    localparam logic [11:0] PU_EDGES = 12'(POWERUP_CYCLES + 1);
    logic [11:0] up_cnt_r;
    // saturates, so a long run never wraps into a false match
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            up_cnt_r <= 12'h000;
        end else begin
            up_cnt_r <= up_cnt_r + {11'h000, ~&up_cnt_r};
        end
    end
    sequence s_ovl_hit;
        weld_active_i && !brake_active_i && current_i >= DEF_CUR_LIM[15:0];
    endsequence
    sequence s_weld_held;
        weld_active_i [*2];
    endsequence
    a_ovl_stop_abort: assert property (s_ovl_hit ##1 s_weld_held |=> cycle_abort_o && $past(sonics_stop_o))
        else $error("no stop then abort");
    a_abort_after_stop: assert property ($rose(cycle_abort_o) |-> $past(sonics_stop_o))
        else $error("abort before stop");
    a_stop_idle_clear: assert property (!weld_active_i |=> !sonics_stop_o && !cycle_abort_o)
        else $error("stop outside weld");
    a_stop_held: assert property (sonics_stop_o && weld_active_i |=> sonics_stop_o)
        else $error("stop dropped");
    a_hot_bit_kept: assert property ($past(temp_i >= DEF_TEMP_THR[15:0], 2) && $past(!rst_i, 2) && $past(!rst_i)
        && $past(rd_i) && $past(addr_i) == OFS_OVL_ALARM |-> rd_data_o[OVL_TEMP])
        else $error("hot bit missing");
    a_version_ro: assert property ($past(rd_i) && $past(addr_i) == OFS_VERSION |-> rd_data_o == VERSION_WORD)
        else $error("version record changed");
    a_ready_time: assert property ($rose(ready_o) |-> up_cnt_r == PU_EDGES)
        else $error("power-up length wrong");
    a_cold_fixed: assert property ($past(ready_o, 2) && !$past(rst_i) |-> $stable(cold_start_o))
        else $error("cold flag moved");
    a_amp_reload: assert property ($rose(cold_start_o) |=> amplitude_o == DEF_AMPLITUDE[15:0])
        else $error("amplitude not reloaded");
endmodule : wam_monitor_chk

bind wam_monitor wam_monitor_chk u_chk (.*);

// ---- wam_io_ctrl.sv ----
// behavioural automation controller on the user connector
module wam_io_ctrl (
    // clock and supply state
    input  wire logic ref_clk_i,
    input  wire logic pwr_down_i,
    // requests from the bench
    input  wire logic strap_req_i,
    input  wire logic weld_req_i,
    input  wire logic sonic_req_i,
    input  wire logic brake_req_i,
    // towards the monitor
    output logic      cold_strap_o,
    output logic      weld_active_o,
    output logic      weld_start_o,
    output logic      sonics_on_o,
    output logic      brake_active_o
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge ref_clk_i) begin
        // the strap is only fitted or removed with the supply off
        if (pwr_down_i) begin
            cold_strap_o <= strap_req_i;
        end
        weld_start_o   <= weld_req_i && !weld_active_o;
        weld_active_o  <= weld_req_i;
        sonics_on_o    <= weld_req_i && sonic_req_i;
        brake_active_o <= weld_req_i && brake_req_i;
    end
endmodule : wam_io_ctrl

// ---- wam_monitor_tb_top.sv ----
// self-checking testbench for the weld alarm monitor
module wam_monitor_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import wam_pkg::*;
    logic        ref_clk_i;
    logic        rst_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wr_data_i = 32'h0;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [15:0] phase_i, current_i, freq_i, power_i, voltage_i, temp_i, ana1_i, ana2_i;
    logic        strap_req = 1'b0, weld_req = 1'b0, sonic_req = 1'b0, brake_req = 1'b0;
    wire  logic  cold_strap_i, weld_active_i, weld_start_i, sonics_on_i, brake_active_i;
    logic [31:0] rd_data_o;
    logic [15:0] amplitude_o;
    logic        sonics_stop_o, cycle_abort_o, irq_o, cold_start_o, ready_o;
    int          err_total = 0;
    int          checks = 0;
    int          cycles = 0;

    wam_monitor #(.MS_CYCLES(10)) DUT (.*);
    wam_io_ctrl u_io (.ref_clk_i, .pwr_down_i(rst_i), .strap_req_i(strap_req), .weld_req_i(weld_req),
        .sonic_req_i(sonic_req), .brake_req_i(brake_req), .cold_strap_o(cold_strap_i),
        .weld_active_o(weld_active_i), .weld_start_o(weld_start_i), .sonics_on_o(sonics_on_i),
        .brake_active_o(brake_active_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    task wrap_up();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up

    // a hang counts as a mismatch
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            wrap_up();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task settle();
        repeat (3) @(negedge ref_clk_i);
    endtask : settle

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_i      <= 1'b1;
        @(posedge ref_clk_i);
        wr_i      <= 1'b0;
    endtask : wr

    // read data stands only in the cycle after the strobe
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        @(negedge ref_clk_i);
        chk(rd_data_o, exp);
    endtask : rchk

    task meas_idle();
        {phase_i, current_i, freq_i, power_i} <= {16'h0000, 16'h0100, 16'h5000, 16'h0100};
        {voltage_i, temp_i, ana1_i, ana2_i}   <= {16'h0100, 16'h0020, 16'h0000, 16'h0000};
    endtask : meas_idle

    task clr_all();
        wr(OFS_OVL_ALARM, 32'hffff_ffff);
        wr(OFS_CUT_ALARM, 32'hffff_ffff);
        wr(OFS_SET_ALARM, 32'hffff_ffff);
        wr(OFS_IRQ_STAT, 32'h0000_000f);
    endtask : clr_all

    task power_up(input logic s);
        @(posedge ref_clk_i);
        rst_i     <= 1'b1;
        strap_req <= s;
        repeat (4) @(posedge ref_clk_i);
        rst_i     <= 1'b0;
        repeat (POWERUP_CYCLES + 2) @(negedge ref_clk_i);
        settle();
        chk(ready_o, 1'b1);
    endtask : power_up

    task wait_stop(input logic ab);
        for (int i = 0; i < 200; i++) begin
            @(negedge ref_clk_i);
            if (sonics_stop_o === 1'b1) break;
        end
        chk(sonics_stop_o, 1'b1);
        @(negedge ref_clk_i);
        chk(cycle_abort_o, ab);
    endtask : wait_stop

    task t_boot();
        chk(cold_start_o, 1'b0);
        chk(amplitude_o, DEF_AMPLITUDE[15:0]);
        rchk(OFS_STATUS, 32'h1);
        rchk(OFS_CFG_BASE + 8'h1c, DEF_TEMP_THR);
        wr(OFS_VERSION, 32'h0);
        rchk(OFS_VERSION, VERSION_WORD);
        rchk(8'hfc, 32'h0);
        $display("boot test done");
    endtask : t_boot

    task t_ovl();
        wr(OFS_IRQ_MASK, 32'h0000_000f);
        for (int k = 0; k < 5; k++) begin
            case (k)
                0: phase_i <= 16'h0201;
                1: current_i <= DEF_CUR_LIM[15:0];
                2: freq_i <= 16'h4e1f;
                3: power_i <= DEF_PWR_LIM[15:0];
                default: voltage_i <= DEF_VOLT_LIM[15:0];
            endcase
            weld_req <= 1'b1;
            if (k == 0) begin
                repeat (30) @(negedge ref_clk_i);
                chk(sonics_stop_o, 1'b0);
            end
            wait_stop(1'b1);
            rchk(OFS_OVL_ALARM, 32'h1 << (k + 1));
            chk(irq_o, 1'b1);
            if (k == 4) begin
                wr(OFS_IRQ_MASK, 32'h0000_000e);
                settle();
                chk(irq_o, 1'b0);
                wr(OFS_IRQ_MASK, 32'h0000_000f);
            end
            weld_req <= 1'b0;
            meas_idle();
            settle();
            chk(sonics_stop_o | cycle_abort_o, 1'b0);
            rchk(OFS_OVL_ALARM, 32'h1 << (k + 1));
            clr_all();
            settle();
            chk(irq_o, 1'b0);
        end
        brake_req <= 1'b1;
        weld_req  <= 1'b1;
        current_i <= DEF_CUR_LIM[15:0];
        settle();
        rchk(OFS_OVL_ALARM, 32'h1 << (OVL_BRAKE0 + 1));
        brake_req <= 1'b0;
        weld_req  <= 1'b0;
        meas_idle();
        clr_all();
        $display("overload test done");
    endtask : t_ovl

    task t_temp();
        temp_i <= DEF_TEMP_THR[15:0];
        settle();
        rchk(OFS_OVL_ALARM, 32'h1 << OVL_TEMP);
        wr(OFS_OVL_ALARM, 32'h1 << OVL_TEMP);
        settle();
        rchk(OFS_OVL_ALARM, 32'h1 << OVL_TEMP);
        temp_i <= DEF_TEMP_THR[15:0] - 16'h0001;
        settle();
        wr(OFS_OVL_ALARM, 32'h1 << OVL_TEMP);
        rchk(OFS_OVL_ALARM, 32'h0);
        meas_idle();
        clr_all();
        $display("temperature test done");
    endtask : t_temp

    task automatic t_cut();
        logic [7:0]  adr[7] = '{8'h40, 8'h44, 8'h48, 8'h4c, 8'h50, 8'h54, 8'h58};
        logic [31:0] val[7] = '{32'h250, 32'h180, 32'h100, 32'h100, 32'h2, 32'h10, 32'h10};
        int          pos[7] = '{CUT_ENERGY, CUT_POWER, CUT_CUST1, CUT_CUST2, CUT_TIME, CUT_FREQ_LO, CUT_FREQ_HI};
        wr(8'h5c, 32'h3);
        for (int k = 0; k < 7; k++) begin
            wr(adr[k], val[k]);
            weld_req  <= 1'b1;
            sonic_req <= 1'b1;
            settle();
            case (k)
                1: power_i <= 16'h0200;
                2: ana1_i <= 16'h0200;
                3: ana2_i <= 16'h0200;
                5: freq_i <= 16'h4fe0;
                6: freq_i <= 16'h5020;
                default: ;
            endcase
            wait_stop(1'b0);
            rchk(OFS_CUT_ALARM, 32'h1 << pos[k]);
            rchk(OFS_OVL_ALARM, 32'h0);
            weld_req  <= 1'b0;
            sonic_req <= 1'b0;
            meas_idle();
            wr(adr[k], 32'h0);
            clr_all();
        end
        $display("cutoff test done");
    endtask : t_cut

    task t_preset();
        wr(OFS_PRESET, MAX_PRESET);
        settle();
        rchk(OFS_SET_ALARM, 32'h0);
        wr(OFS_PRESET, MAX_PRESET + 32'h1);
        settle();
        rchk(OFS_SET_ALARM, 32'h1 << SET_PRESET);
        rchk(OFS_IRQ_STAT, 32'h1 << IRQ_SET);
        rchk(OFS_PRESET, MAX_PRESET + 32'h1);
        clr_all();
        $display("preset test done");
    endtask : t_preset

    task t_cold();
        wr(8'h60, 32'h0000_0010);
        wr(8'h68, 32'h0000_1234);
        settle();
        chk(amplitude_o, 16'h0010);
        rchk(8'h68, 32'h0000_1234);
        power_up(1'b1);
        chk(cold_start_o, 1'b1);
        chk(amplitude_o, DEF_AMPLITUDE[15:0]);
        rchk(8'h68, 32'h0);
        rchk(8'h64, DEF_NET_ADDR);
        rchk(OFS_VERSION, VERSION_WORD);
        rchk(OFS_IRQ_STAT, 32'h1 << IRQ_COLD);
        rchk(OFS_STATUS, 32'h3);
        power_up(1'b0);
        chk(cold_start_o, 1'b0);
        $display("cold start test done");
    endtask : t_cold

    initial begin
        meas_idle();
        power_up(1'b0);
        t_boot();
        t_ovl();
        t_temp();
        t_cut();
        t_preset();
        t_cold();
        wrap_up();
    end
endmodule : wam_monitor_tb_top
